// >>> bench/host_port_model.sv
// Purpose: Host side of the register port, one access per call
// Assumes: Calls are made at a falling edge of core_clk
// Notes: Released address and data lines show the inverse of their last value; both strobes go low
module host_port_model (
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic core_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe a cycle; never both strobes, so no clash
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
  endtask
  // Inverted lines so a stale value is never mistaken for a live one
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(negedge core_clk);
  endtask
endmodule

// >>> bench/motion_event_chk.sv
// Purpose: Port assertions for the motion-event register block
// Assumes: Sync active-low reset; clk_en qualifies every edge
// Notes: Inactivity enable is shadowed from host writes
module motion_event_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic buffer_overrun,
  input wire logic temp_ready,
  input wire logic accel_ready,
  input wire logic orientation_change,
  input wire logic stationary_mode,
  input wire logic inactive_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Shadow state and sequences
  // ****
  logic sleep_en_q;
  // Shadow kept here so sleep can be tied to its enable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleep_en_q <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == 8'h34) begin
      sleep_en_q <= reg_wdata[6];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_at(logic [7:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  // ****
  // Assertions
  // ****
  a_stat_follow: assert property (clk_en && reg_wr && reg_addr == 8'h35
    |=> stationary_mode == $past(reg_wdata[4])) else $error("stationary output wrong");
  a_unmapped_zero: assert property (clk_en && reg_rd
    && !(reg_addr inside {8'h30, [8'h32:8'h37]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_level_flags: assert property (rd_at(8'h37) ##0 ($past(rst_n)
    && $stable({buffer_overrun, temp_ready, accel_ready}))
    |=> {reg_rdata[7:6], reg_rdata[0]} == $past({buffer_overrun, temp_ready, accel_ready}))
    else $error("level flags wrong");
  a_orient_set: assert property (orientation_change && clk_en ##1 rd_at(8'h37)
    |=> reg_rdata[2]) else $error("orientation flag missing");
  a_read_clear: assert property (rd_at(8'h37) ##0 !orientation_change
    ##1 rd_at(8'h37) ##0 !orientation_change |=> !reg_rdata[2])
    else $error("orientation flag not cleared");
  a_sleep_needs_en: assert property ($rose(inactive_state) |-> $past(sleep_en_q))
    else $error("sleep without enable");
  a_sleep_off: assert property (!sleep_en_q && !$past(sleep_en_q) |-> !inactive_state)
    else $error("sleep while disabled");
  a_enable_freeze: assert property (!clk_en |=> $stable(reg_rdata)
    && $stable(stationary_mode) && $stable(inactive_state)) else $error("state moved");
endmodule

bind motion_event_config_status motion_event_chk i_motion_event_chk (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .buffer_overrun(buffer_overrun), .temp_ready(temp_ready), .accel_ready(accel_ready),
  .orientation_change(orientation_change), .stationary_mode(stationary_mode),
  .inactive_state(inactive_state));

// >>> bench/motion_event_config_status_tb_top.sv
// Purpose: Self-checking bench for the motion-event register block
// Assumes: Reads answer one cycle after the read edge
// Notes: Reads queue a mask and value; a monitor compares them
module motion_event_config_status_tb_top
  import motion_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, clk_en, sample_tick, tick_on, orientation_change;
  logic reg_wr, reg_rd, rd_seen, wake_event, stationary_mode, inactive_state;
  logic [2:0] lvl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] accel, ent;
  logic [15:0] exp_q[$];
  logic [7:0] regs[6] = '{8'h30, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
  logic [7:0] sh[6];
  logic [31:0] seed = 32'ha6c2;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  motion_event_config_status i_motion_event_config_status (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .accel_x(accel), .accel_y(accel), .accel_z(accel),
    .buffer_overrun(lvl[2]), .temp_ready(lvl[1]), .orientation_change(orientation_change),
    .accel_ready(lvl[0]), .wake_event(wake_event), .stationary_mode(stationary_mode),
    .inactive_state(inactive_state));
  host_port_model i_host_port_model (.reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .core_clk(core_clk));
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("Error at %0t: got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    i_host_port_model.access(1'b0, a, 8'h00);
  endtask
  // One short excursion on all three axes, then n quiet cycles
  task automatic tap(input int n);
    accel = 16'h0100;
    repeat (2) @(negedge core_clk);
    accel = 16'h0000;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // Clock, ticks, monitor, watchdog
  // ****
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Tick every other cycle, so it stays a true one-cycle pulse
  always @(negedge core_clk) sample_tick <= tick_on && !sample_tick;
  always @(posedge core_clk) rd_seen <= rst_n && clk_en && reg_rd;
  // Read data is settled by the falling edge after the read
  always @(negedge core_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      chk(reg_rdata & ent[15:8], ent[7:0] & ent[15:8]);
    end
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  // ****
  // Tests
  // ****
  initial begin
    {rst_n, clk_en, tick_on, orientation_change} = 4'b0100;
    lvl = 3'h0;
    accel = 16'h0000;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (regs[i]) rdx(regs[i], 8'h00, 8'hff);
    rdx(8'h37, 8'h00, 8'hff);
    done("reset");
    // Back-to-back write then read of every config register
    foreach (regs[i]) begin
      d = xs();
      sh[i] = (i == 0) ? (d & 8'h1f) : d;
      i_host_port_model.access(1'b1, regs[i], sh[i]);
      if (i == 4) chk({7'h00, stationary_mode}, {7'h00, d[4]});
      rdx(regs[i], sh[i], 8'hff);
    end
    i_host_port_model.access(1'b1, 8'h37, 8'hff);
    i_host_port_model.access(1'b1, 8'h50, 8'h5a);
    rdx(8'h37, 8'h00, 8'hff);
    rdx(8'h50, 8'h00, 8'hff);
    clk_en = 1'b0;
    i_host_port_model.access(1'b1, 8'h33, ~sh[2]);
    clk_en = 1'b1;
    rdx(8'h33, sh[2], 8'hff);
    done("registers");
    repeat (4) begin
      d = xs();
      lvl = d[2:0];
      i_host_port_model.idle();
      rdx(8'h37, {lvl[2:1], 5'h00, lvl[0]}, 8'hff);
    end
    orientation_change = 1'b1;
    i_host_port_model.idle();
    orientation_change = 1'b0;
    rdx(8'h37, {lvl[2:1], 5'h02, lvl[0]}, 8'hff);
    rdx(8'h37, {lvl[2:1], 5'h00, lvl[0]}, 8'hff);
    done("status");
    // Sleep after 16 quiet ticks; one loud sample restarts the count
    i_host_port_model.access(1'b1, 8'h32, 8'h00);
    i_host_port_model.access(1'b1, 8'h35, 8'h00);
    i_host_port_model.access(1'b1, 8'h34, 8'h41);
    tick_on = 1'b1;
    repeat (20) @(negedge core_clk);
    chk({7'h00, inactive_state}, 8'h00);
    accel = 16'h4000;
    repeat (2) @(negedge core_clk);
    chk({7'h00, wake_event}, 8'h01);
    accel = 16'h0000;
    repeat (28) @(negedge core_clk);
    chk({7'h00, inactive_state}, 8'h00);
    chk({7'h00, wake_event}, 8'h00);
    n = 0;
    while (inactive_state !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, inactive_state}, 8'h01);
    // Status copy trails the sleep state by one cycle
    i_host_port_model.idle();
    rdx(8'h37, {lvl[2:1], 5'h10, lvl[0]}, 8'he1);
    i_host_port_model.access(1'b1, 8'h34, 8'h01);
    i_host_port_model.idle();
    i_host_port_model.idle();
    chk({7'h00, inactive_state}, 8'h00);
    done("sleep");
    // Z only, level 1, shortest windows; single mode first, then double
    i_host_port_model.access(1'b1, 8'h32, 8'h21);
    i_host_port_model.access(1'b1, 8'h33, 8'h00);
    i_host_port_model.access(1'b1, 8'h34, 8'h00);
    tap(12);
    rdx(8'h37, 8'h08, 8'h18);
    i_host_port_model.access(1'b1, 8'h34, 8'h80);
    tap(8);
    tap(12);
    rdx(8'h37, 8'h10, 8'h18);
    tick_on = 1'b0;
    done("tap");
    wrap_up();
  end
endmodule

// >>> hdl/duration_counter.sv
// Purpose: Counts sample ticks while a condition holds
// Assumes: tick is a one-cycle pulse per sample period
// Notes: Saturates at all ones; clears as soon as the condition drops
module duration_counter #(
  parameter int WIDTH = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic hold,
  output logic [WIDTH-1:0] count
);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clk_en) begin
      if (!hold) begin
        count <= '0;
      end else if (tick && count != {WIDTH{1'b1}}) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

// >>> hdl/motion_event_config_status.sv
// Purpose: Configuration registers and event engines for tap, wake, sleep and fall
// Assumes: Samples arrive with sample_tick; register port is synchronous, one access a cycle
// Notes: Status copy is read-only; event flags clear when the host reads the copy
// Function
// - Each axis has its own tap enable; 1 includes it, 0 excludes it
// - Z data is compared against a 5-bit tap threshold
// - Second tap must come within the gap window; code 0 is 16, step 32
// - No over-threshold during quiet window; code 0 is 2, step 4
// - Tap excursion lasts no longer than shock window; code 0 is 4, step 8
// - Tap mode bit: 0 single only, 1 single and double
// - Inactivity enable bit, default 0, turns sleep detection on
// - Wake threshold is 6-bit unsigned, resets to zero
// - Wake hold time is 2-bit in sample periods
// - Stationary bit enables detection without rate change
// - Sleep delay 4-bit; code 0 is 16, step 512 samples
// - Fall time is 6 bits: msb in wake register, five low bits
// - Fall level code decodes to 5,7,8,10,11,13,15,16 LSB
// - Status reports buffer overrun flag
// - Status reports temperature ready
// - Status reports inactivity detected
// - Status reports double-tap and single-tap separately
// - Status reports orientation change
// - Status reports free-fall detected
// - Status reports all-axis data ready
// - X tap threshold is a 5-bit field in its own register
module motion_event_config_status
  import motion_event_pkg::*;
#(
  parameter int CNT_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic [15:0] accel_x,
  input wire logic [15:0] accel_y,
  input wire logic [15:0] accel_z,
  input wire logic buffer_overrun,
  input wire logic temp_ready,
  input wire logic orientation_change,
  input wire logic accel_ready,
  output logic wake_event,
  output logic stationary_mode,
  output logic inactive_state
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [13:0] window_ticks(input logic [3:0] code,
                                               input logic [13:0] zero,
                                               input logic [13:0] step);
    window_ticks = (code == 4'h0) ? zero : 14'(code * step);
  endfunction

  // Magnitude of a sample in 8-bit scale, top bits of the 16-bit word
  function automatic logic [7:0] mag8(input logic [15:0] v);
    logic [15:0] a;
    a = v[15] ? 16'(~v + 16'h0001) : v;
    mag8 = a[14:7];
  endfunction

  function automatic logic [7:0] fall_level(input logic [2:0] code);
    unique case (code)
      3'h0: fall_level = 8'h05;
      3'h1: fall_level = 8'h07;
      3'h2: fall_level = 8'h08;
      3'h3: fall_level = 8'h0a;
      3'h4: fall_level = 8'h0b;
      3'h5: fall_level = 8'h0d;
      3'h6: fall_level = 8'h0f;
      3'h7: fall_level = 8'h10;
    endcase
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] tap_z_cfg_q;
  logic [7:0] tap_time_q;
  logic [7:0] wake_cfg_q;
  logic [7:0] wake_hold_time_q;
  logic [7:0] fall_cfg_q;
  logic [7:0] tap_x_cfg_q;

  // Host writes; the status copy has no write path
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tap_z_cfg_q <= REG_RESET;
      tap_time_q <= REG_RESET;
      wake_cfg_q <= REG_RESET;
      wake_hold_time_q <= REG_RESET;
      fall_cfg_q <= REG_RESET;
      tap_x_cfg_q <= REG_RESET;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        TAP_AXIS_EN_Z_THS_ADDR: tap_z_cfg_q <= reg_wdata;
        TAP_TIMING_ADDR: tap_time_q <= reg_wdata;
        WAKEUP_THS_ADDR: wake_cfg_q <= reg_wdata;
        WAKEUP_INACTIVITY_DELAY_ADDR: wake_hold_time_q <= reg_wdata;
        FREEFALL_CFG_ADDR: fall_cfg_q <= reg_wdata;
        TAP_X_THS_ADDR: tap_x_cfg_q <= {3'b000, reg_wdata[4:0]};
        default: ;
      endcase
    end
  end

  // Field views
  logic [4:0] tap_level_z;
  logic [4:0] tap_level_x;
  logic [3:0] double_tap_gap;
  logic [5:0] wake_level;
  logic [1:0] wake_hold_time;
  logic [3:0] inactivity_delay;
  logic [5:0] fall_time;
  logic [2:0] fall_level_code;
  logic tap_mode_double;
  logic inact_en;
  assign tap_level_z = tap_z_cfg_q[4:0];
  assign tap_level_x = tap_x_cfg_q[4:0];
  assign double_tap_gap = tap_time_q[7:4];
  assign tap_mode_double = wake_cfg_q[TAP_MODE_BIT];
  assign inact_en = wake_cfg_q[INACT_EN_BIT];
  assign wake_level = wake_cfg_q[5:0];
  assign wake_hold_time = wake_hold_time_q[6:5];
  assign inactivity_delay = wake_hold_time_q[3:0];
  assign fall_time = {wake_hold_time_q[FALL_MSB_BIT], fall_cfg_q[7:3]};
  assign fall_level_code = fall_cfg_q[2:0];
  assign stationary_mode = wake_hold_time_q[STATIONARY_BIT];

  // ****************************************
  // Sample conditions
  // ****************************************
  logic [7:0] mx;
  logic [7:0] my;
  logic [7:0] mz;
  logic over_tap;
  logic over_wake;
  logic in_fall;
  assign mx = mag8(accel_x);
  assign my = mag8(accel_y);
  assign mz = mag8(accel_z);
  assign over_tap = (tap_z_cfg_q[TAP_X_EN_BIT] && mx > {3'b000, tap_level_x})
                 || (tap_z_cfg_q[TAP_Y_EN_BIT] && my > {3'b000, tap_level_x})
                 || (tap_z_cfg_q[TAP_Z_EN_BIT] && mz > {3'b000, tap_level_z});
  // Wake level is 1/64 of full scale, so compare against the top six magnitude bits
  assign over_wake = (mx[7:2] > wake_level) || (my[7:2] > wake_level)
                  || (mz[7:2] > wake_level);
  assign in_fall = (mx < fall_level(fall_level_code)) && (my < fall_level(fall_level_code))
                && (mz < fall_level(fall_level_code));

  // ****************************************
  // Duration counters
  // ****************************************
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] still_cnt;
  logic [CNT_W-1:0] fall_cnt;

  duration_counter #(.WIDTH(CNT_W)) u_wake (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(sample_tick),
    .hold(over_wake), .count(wake_cnt));
  duration_counter #(.WIDTH(CNT_W)) u_still (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(sample_tick),
    .hold(inact_en && !over_wake), .count(still_cnt));
  duration_counter #(.WIDTH(CNT_W)) u_fall (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(sample_tick),
    .hold(in_fall), .count(fall_cnt));

  // wake hold, event once the excursion outlasts the hold
  assign wake_event = (wake_cnt > CNT_W'(wake_hold_time)) && over_wake;

  // ****************************************
  // Tap engine
  // ****************************************
  tap_state_t tap_st_q;
  logic [13:0] tap_cnt_q;
  logic single_pulse;
  logic double_pulse;
  logic [13:0] shock_lim;
  logic [13:0] quiet_lim;
  logic [13:0] gap_lim;
  assign shock_lim = window_ticks({2'b00, tap_time_q[1:0]}, SHOCK_ZERO_TICKS, SHOCK_STEP_TICKS);
  assign quiet_lim = window_ticks({2'b00, tap_time_q[3:2]}, QUIET_ZERO_TICKS, QUIET_STEP_TICKS);
  assign gap_lim = window_ticks(double_tap_gap, GAP_ZERO_TICKS, GAP_STEP_TICKS);

  // Sequencer steps on sample ticks only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tap_st_q <= TAP_IDLE;
      tap_cnt_q <= 14'h0000;
      single_pulse <= 1'b0;
      double_pulse <= 1'b0;
    end else if (clk_en) begin
      single_pulse <= 1'b0;
      double_pulse <= 1'b0;
      if (sample_tick) begin
        tap_cnt_q <= tap_cnt_q + 14'h0001;
        unique case (tap_st_q)
          TAP_IDLE: begin
            tap_cnt_q <= 14'h0000;
            if (over_tap) tap_st_q <= TAP_SHOCK;
          end
          // excursion too long is no tap
          TAP_SHOCK: begin
            if (!over_tap) begin
              tap_cnt_q <= 14'h0000;
              tap_st_q <= TAP_QUIET;
            end else if (tap_cnt_q >= shock_lim) begin
              tap_st_q <= TAP_IDLE;
            end
          end
          TAP_QUIET: begin
            if (over_tap) begin
              tap_st_q <= TAP_IDLE;
            end else if (tap_cnt_q + 14'h0001 >= quiet_lim) begin
              tap_cnt_q <= 14'h0000;
              if (tap_mode_double) begin
                tap_st_q <= TAP_GAP;
              end else begin
                single_pulse <= 1'b1;
                tap_st_q <= TAP_IDLE;
              end
            end
          end
          TAP_GAP: begin
            if (over_tap) begin
              double_pulse <= 1'b1;
              tap_st_q <= TAP_IDLE;
            end else if (tap_cnt_q + 14'h0001 >= gap_lim) begin
              single_pulse <= 1'b1;
              tap_st_q <= TAP_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Sleep and fall detection
  // ****************************************
  logic [13:0] sleep_lim;
  logic sleep_q;
  logic fall_hit;
  assign sleep_lim = window_ticks(inactivity_delay, SLEEP_ZERO_TICKS, SLEEP_STEP_TICKS);
  assign fall_hit = in_fall && (fall_cnt >= CNT_W'(fall_time)) && (fall_cnt != '0);

  // Sleep state follows the still counter; wake clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleep_q <= 1'b0;
    end else if (clk_en) begin
      if (!inact_en || over_wake) begin
        sleep_q <= 1'b0;
      end else if (still_cnt >= CNT_W'(sleep_lim)) begin
        sleep_q <= 1'b1;
      end
    end
  end
  assign inactive_state = sleep_q;

  // ****************************************
  // Status copy
  // ****************************************
  logic [7:0] evt_q;
  logic status_rd;
  assign status_rd = reg_rd && reg_addr == EVENT_STATUS_ADDR;

  // Sticky event bits; a new event beats the read clear so none is lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_q <= REG_RESET;
    end else if (clk_en) begin
      evt_q[ST_SLEEP] <= sleep_q;
      evt_q[ST_DTAP] <= double_pulse || (evt_q[ST_DTAP] && !status_rd);
      evt_q[ST_STAP] <= single_pulse || (evt_q[ST_STAP] && !status_rd);
      evt_q[ST_FALL] <= fall_hit || (evt_q[ST_FALL] && !status_rd);
      evt_q[ST_ORIENT] <= orientation_change || (evt_q[ST_ORIENT] && !status_rd);
      evt_q[ST_OVR] <= buffer_overrun;
      evt_q[ST_TEMP] <= temp_ready;
      evt_q[ST_ACCEL_READY_FLAG] <= accel_ready;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Registered read: data shows one cycle after reg_rd; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        TAP_AXIS_EN_Z_THS_ADDR: reg_rdata <= tap_z_cfg_q;
        TAP_TIMING_ADDR: reg_rdata <= tap_time_q;
        WAKEUP_THS_ADDR: reg_rdata <= wake_cfg_q;
        WAKEUP_INACTIVITY_DELAY_ADDR: reg_rdata <= wake_hold_time_q;
        FREEFALL_CFG_ADDR: reg_rdata <= fall_cfg_q;
        EVENT_STATUS_ADDR: reg_rdata <= evt_q;
        TAP_X_THS_ADDR: reg_rdata <= tap_x_cfg_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> include/motion_event_pkg.sv
// Purpose: Shared constants for the motion-event configuration and status block
// Assumes: Register addresses are 8-bit, data is 8-bit
// Notes: Window codes map to sample counts through functions in the main module
package motion_event_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] TAP_AXIS_EN_Z_THS_ADDR = 8'h32;
  localparam logic [7:0] TAP_TIMING_ADDR = 8'h33;
  localparam logic [7:0] WAKEUP_THS_ADDR = 8'h34;
  localparam logic [7:0] WAKEUP_INACTIVITY_DELAY_ADDR = 8'h35;
  localparam logic [7:0] FREEFALL_CFG_ADDR = 8'h36;
  localparam logic [7:0] EVENT_STATUS_ADDR = 8'h37;
  localparam logic [7:0] TAP_X_THS_ADDR = 8'h30;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TAP_X_EN_BIT = 7;
  localparam int TAP_Y_EN_BIT = 6;
  localparam int TAP_Z_EN_BIT = 5;
  localparam int TAP_MODE_BIT = 7;
  localparam int INACT_EN_BIT = 6;
  localparam int FALL_MSB_BIT = 7;
  localparam int STATIONARY_BIT = 4;
  localparam int ST_OVR = 7;
  localparam int ST_TEMP = 6;
  localparam int ST_SLEEP = 5;
  localparam int ST_DTAP = 4;
  localparam int ST_STAP = 3;
  localparam int ST_ORIENT = 2;
  localparam int ST_FALL = 1;
  localparam int ST_ACCEL_READY_FLAG = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // Timing in sample periods
  // ****************************************
  localparam logic [13:0] GAP_ZERO_TICKS = 14'd16;
  localparam logic [13:0] GAP_STEP_TICKS = 14'd32;
  localparam logic [13:0] QUIET_ZERO_TICKS = 14'd2;
  localparam logic [13:0] QUIET_STEP_TICKS = 14'd4;
  localparam logic [13:0] SHOCK_ZERO_TICKS = 14'd4;
  localparam logic [13:0] SHOCK_STEP_TICKS = 14'd8;
  localparam logic [13:0] SLEEP_ZERO_TICKS = 14'd16;
  localparam logic [13:0] SLEEP_STEP_TICKS = 14'd512;

  // Tap engine states, Gray along idle-shock-quiet-gap
  typedef enum logic [1:0] {
    TAP_IDLE = 2'b00,
    TAP_SHOCK = 2'b01,
    TAP_QUIET = 2'b11,
    TAP_GAP = 2'b10
  } tap_state_t;
endpackage
